// file: inc/watchdog_regs.vh
// watchdog register offset, field positions, reset values and timing counts
// assumes a byte-wide register port on the core data space
`ifndef WATCHDOG_REGS_VH
`define WATCHDOG_REGS_VH
`define WDOG_ADDR 8'h0D8
`define WDOG_RESET_VAL 8'h0FE
`define WDOG_BIT_ACT 0
`define WDOG_BIT_TRIG 1
`define WDOG_STAT_ADDR 8'h0DF
`define RESET_VECTOR 12'h0FFE
`define TICK_CYCLES 12'd3072
`define TICK_MAX 12'd3071
`define MIN_INSTR 6'd28
`define STAB_CYCLES 12'd4095
`endif

// file: hw/watchdog_reset_init.v
// digital watchdog with reset generation and core initialisation hooks
// assumes the core reports instruction retirement, stop/wait requests and return-from-interrupt
`timescale 1ns/1ps
`include "watchdog_regs.vh"
module watchdog_reset_init #(
    parameter STAB_LEN = `STAB_CYCLES
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire opt_hw_activation,
    input wire opt_ext_stop_ctrl,
    input wire nmi_pin,
    input wire ext_reset_n_in,
    output reg ext_reset_n_out,
    output reg ext_reset_n_oe,
    input wire instr_retired,
    input wire stop_request,
    input wire wait_request,
    input wire return_from_interrupt_instr_executed,
    input wire irq_pending,
    input wire nmi_request,
    input wire global_interrupt_enable,
    output reg core_reset,
    output reg stack_clear,
    output reg [11:0] pc_load_value,
    output reg nmi_mode,
    output reg service_irq,
    output reg core_wait,
    output reg core_stop,
    output reg service_nmi
);
    // state of the low-power / reset sequencer, one-hot
    localparam ST_RESET = 4'b0001;
    localparam ST_RUN = 4'b0010;
    localparam ST_WAIT = 4'b0100;
    localparam ST_STOP = 4'b1000;

    // limitation: the pin is driven low throughout the reset state, so a pin reset
    // during the stabilisation wait is masked by our own drive and does not restart the wait
    reg [3:0] state;
    reg [3:0] next_state;
    reg [6:0] count;          // physical downcounter, bit 6 is the trigger
    reg active;
    reg opt_hw;
    reg opt_stop;
    reg [11:0] prescale;
    reg [11:0] stab_count;
    reg [5:0] instr_count;
    reg wd_reset;
    reg [2:0] nmi_sync;
    reg [2:0] rst_sync;
    reg nmi_level;
    reg pin_reset;
    reg opts_taken;
    wire [7:0] reg_view;
    wire rd_ctrl;
    wire rd_stat;
    wire [7:0] next_count_wr;
    wire frozen;
    wire tick;
    wire wr_hit;
    wire guard_ok;
    wire stop_is_wait;

    // register view with reversed period bits
    genvar i;
    generate
        for (i = 0; i < 6; i = i + 1) begin : g_rev
            // write and read paths mirror each other bit for bit
            assign next_count_wr[i] = reg_wdata[7 - i];
            assign reg_view[7 - i] = count[i];
        end
    endgenerate

    // trigger sits beside the activation bit, not in the period field
    assign next_count_wr[6] = reg_wdata[`WDOG_BIT_TRIG];
    // spare bit keeps the write image byte-wide; never loaded
    assign next_count_wr[7] = 1'b0;
    // trigger bit reads the physical counter msb directly
    assign reg_view[`WDOG_BIT_TRIG] = count[6];
    // hardware option forces the bit high whatever was written
    assign reg_view[`WDOG_BIT_ACT] = active | opt_hw;

    assign wr_hit = reg_wr && (reg_addr == `WDOG_ADDR);
    assign frozen = (state == ST_STOP);
    assign tick = (prescale == `TICK_MAX) && !frozen;
    assign guard_ok = (instr_count >= `MIN_INSTR);
    // hardware option or activation turns stops into waits unless pin high under stop control
    assign stop_is_wait = (opt_hw | active) && !(opt_stop && nmi_level);

    // nmi pin synchroniser: three stages, level accepted once the last two agree
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_sync <= 3'b000;
            nmi_level <= 1'b0;
        end else begin
            nmi_sync <= {nmi_sync[1:0], nmi_pin};
            if (nmi_sync[2] == nmi_sync[1])
                nmi_level <= nmi_sync[2];
        end
    end

    // reset pin synchroniser; the pin also sees our own drive, so only
    // lows seen while we are not driving it count as an external request
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_sync <= 3'b111;
            pin_reset <= 1'b0;
        end else begin
            rst_sync <= {rst_sync[1:0], ext_reset_n_in};
            if (rst_sync[2] == rst_sync[1])
                pin_reset <= !rst_sync[2] && ext_reset_n_oe == 1'b0;
        end
    end

    // options captured once after reset release; static afterwards
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            opts_taken <= 1'b0;
            opt_hw <= 1'b0;
            opt_stop <= 1'b0;
        end else if (!opts_taken) begin
            opts_taken <= 1'b1;
            opt_hw <= opt_hw_activation;
            opt_stop <= opt_ext_stop_ctrl;
        end
    end

    // prescaler: one tick per period, held in reset and while frozen in stop
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            prescale <= 12'h000;
        else if (state == ST_RESET)
            prescale <= 12'h000;
        else if (tick)
            prescale <= 12'h000;
        else if (!frozen)
            prescale <= prescale + 12'd1;
    end

    // instruction guard: restarts on reset and on activation, saturates
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            instr_count <= 6'h00;
        else if (state == ST_RESET)
            instr_count <= 6'h00;
        else if (wr_hit && reg_wdata[`WDOG_BIT_ACT] && !active)
            instr_count <= 6'h00;
        else if (instr_retired && !guard_ok)
            instr_count <= instr_count + 6'd1;
    end

    // activation: only a set is honoured, so it sticks until a device reset
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            active <= 1'b0;
        else if (state == ST_RESET)
            active <= 1'b0;
        else if (wr_hit && reg_wdata[`WDOG_BIT_ACT])
            active <= 1'b1;
    end

    // downcounter and trigger; a write reloads and wins over a tick
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            count <= 7'h7F;
            wd_reset <= 1'b0;
        end else if (state == ST_RESET) begin
            // a device reset returns the counter to its power-up value
            count <= 7'h7F;
            wd_reset <= 1'b0;
        end else begin
            if (wr_hit) begin
                count <= next_count_wr[6:0];
                if (!reg_wdata[`WDOG_BIT_TRIG])
                    wd_reset <= 1'b1;
            end else if (tick) begin
                count <= count - 7'd1;
                // trigger falls one to zero; only fires when enabled and guarded
                if (count[6] && count[5:0] == 6'h00 && (active | opt_hw) && guard_ok)
                    wd_reset <= 1'b1;
            end
        end
    end

    // next state of the reset / power-mode sequencer; reset sources win
    always @* begin
        next_state = state;
        case (state)
            ST_RESET: begin
                // same stabilisation wait for pin and watchdog sources
                if (!pin_reset && stab_count == STAB_LEN[11:0])
                    next_state = ST_RUN;
            end
            ST_RUN: begin
                if (wd_reset || pin_reset)
                    next_state = ST_RESET;
                else if (stop_request && !stop_is_wait)
                    next_state = ST_STOP;
                else if (stop_request || wait_request)
                    next_state = ST_WAIT;
            end
            ST_WAIT: begin
                // the counter keeps running here, so its reset still applies
                if (wd_reset || pin_reset)
                    next_state = ST_RESET;
                else if ((irq_pending || nmi_request) && global_interrupt_enable)
                    next_state = ST_RUN;
            end
            ST_STOP: begin
                // counter is frozen, so only the pin can reset from here
                if (pin_reset)
                    next_state = ST_RESET;
                else if ((irq_pending || nmi_request) && global_interrupt_enable)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RESET;
        endcase
    end

    // sequencer state register
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            state <= ST_RESET;
        else
            state <= next_state;
    end

    // stabilisation wait: counts only in reset; pin_reset would restart it, but our own drive masks the pin there
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            stab_count <= 12'h000;
        else if (state != ST_RESET || pin_reset)
            stab_count <= 12'h000;
        else if (stab_count != STAB_LEN[11:0])
            stab_count <= stab_count + 12'd1;
    end

    // reset-facing outputs; the vector is constant but registered like the rest
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_reset <= 1'b1;
            stack_clear <= 1'b1;
            pc_load_value <= `RESET_VECTOR;
        end else begin
            core_reset <= (state == ST_RESET);
            stack_clear <= (state == ST_RESET);
            pc_load_value <= `RESET_VECTOR;
        end
    end

    // interrupt mode: nmi mode from reset until the first return
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            nmi_mode <= 1'b1;
            service_irq <= 1'b0;
            service_nmi <= 1'b0;
        end else begin
            if (state == ST_RESET)
                nmi_mode <= 1'b1;
            else if (return_from_interrupt_instr_executed)
                nmi_mode <= 1'b0;
            // on the return that ends nmi mode, a pending interrupt is taken before the next instruction
            service_irq <= return_from_interrupt_instr_executed && nmi_mode && irq_pending;
            // nmi is serviced whatever the global enable says
            service_nmi <= nmi_request && (state != ST_RESET);
        end
    end

    // power-mode outputs follow the sequencer one cycle late
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_wait <= 1'b0;
            core_stop <= 1'b0;
        end else begin
            core_wait <= (state == ST_WAIT);
            core_stop <= (state == ST_STOP);
        end
    end

    // reset pin: open-drain low while any internal source holds reset
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ext_reset_n_out <= 1'b0;
            ext_reset_n_oe <= 1'b1;
        end else begin
            ext_reset_n_out <= 1'b0;
            ext_reset_n_oe <= (state == ST_RESET) || wd_reset;
        end
    end

    // read decode; unmapped addresses read as zero
    assign rd_ctrl = reg_rd && (reg_addr == `WDOG_ADDR);
    assign rd_stat = reg_rd && (reg_addr == `WDOG_STAT_ADDR);

    // register read port, data one cycle after the strobe
    always @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst)
            reg_rdata <= 8'h00;
        else if (rd_ctrl)
            reg_rdata <= reg_view;
        else if (rd_stat)
            reg_rdata <= {4'h0, opt_stop, opt_hw, guard_ok, nmi_level};
        else
            reg_rdata <= 8'h00;
    end
endmodule // watchdog_reset_init

// file: bench/core_model.sv
// core model: retires one instruction per running cycle, issues return_from_interrupt_instr or stop on command
// assumes the bench raises cmd for exactly one cycle
`timescale 1ns/1ps
module core_model (
    input wire core_clk,
    input wire core_reset,
    input wire core_wait,
    input wire core_stop,
    input wire [1:0] cmd,
    output logic instr_retired = 1'h0,
    output logic return_from_interrupt_instr_executed = 1'h0,
    output logic stop_request = 1'h0
);
    // registered so every pulse lands just after an edge, as from a real core
    always @(posedge core_clk) begin
        instr_retired <= !core_reset && !core_wait && !core_stop;
        return_from_interrupt_instr_executed <= !core_reset && cmd == 2'h1;
        stop_request <= !core_reset && cmd == 2'h2;
    end
endmodule // core_model

// file: bench/watchdog_checker.sv
// checker: reset, register and power-mode relations at the watchdog ports
// assumes one clock and the high asynchronous reset of the block
`timescale 1ns/1ps
module watchdog_checker (
    input wire core_clk, sys_rst, reg_wr, reg_rd, opt_hw_activation, opt_ext_stop_ctrl,
    input wire return_from_interrupt_instr_executed, irq_pending, core_reset, nmi_mode, service_irq,
    input wire core_stop, ext_reset_n_out, ext_reset_n_oe,
    input wire [7:0] reg_addr, reg_wdata, reg_rdata,
    input wire [11:0] pc_load_value
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_vector_load: assert property (pc_load_value == 12'h0FFE)
        else $error("reset vector wrong");
    a_nmi_start: assert property ($fell(core_reset) |-> nmi_mode)
        else $error("core left reset outside nmi mode");
    a_return_from_interrupt_instr_service: assert property (nmi_mode && return_from_interrupt_instr_executed && irq_pending && !core_reset
        |=> service_irq) else $error("pending request not serviced");
    a_soft_trigger: assert property (reg_wr && reg_addr == 8'hD8 && !reg_wdata[1]
        && !core_reset |-> ##[1:4] core_reset) else $error("trigger clear gave no reset");
    a_pin_drive: assert property (core_reset |-> ext_reset_n_oe && !ext_reset_n_out)
        else $error("reset pin not driven low");
    a_hw_reads_one: assert property (reg_rd && reg_addr == 8'hD8 && opt_hw_activation
        |=> reg_rdata[0]) else $error("activation bit reads zero");
    a_hw_no_stop: assert property (opt_hw_activation && !opt_ext_stop_ctrl |-> !core_stop)
        else $error("stop entered with watchdog forced on");
    a_reset_hold: assert property ($rose(core_reset) |=> core_reset [*8])
        else $error("internal reset too short");
    c_service: cover property ($rose(service_irq));
    c_reset: cover property ($rose(core_reset));
    c_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule // watchdog_checker

bind watchdog_reset_init watchdog_checker chk (.core_clk(core_clk), .sys_rst(sys_rst),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .opt_hw_activation(opt_hw_activation),
    .opt_ext_stop_ctrl(opt_ext_stop_ctrl), .return_from_interrupt_instr_executed(return_from_interrupt_instr_executed),
    .irq_pending(irq_pending), .core_reset(core_reset), .nmi_mode(nmi_mode),
    .service_irq(service_irq), .core_stop(core_stop), .ext_reset_n_out(ext_reset_n_out),
    .ext_reset_n_oe(ext_reset_n_oe), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .pc_load_value(pc_load_value));

// file: bench/test_digital_watchdog_reset_init.sv
// bench: resets the watchdog, drives its register port and judges the reset behaviour
// assumes the core model retires one instruction per running cycle
`timescale 1ns/1ps
module test_digital_watchdog_reset_init;
    logic core_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic reg_wr = 1'h0, reg_rd = 1'h0, opt_hw_activation = 1'h0, irq_pending = 1'h0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rd;
    logic [1:0] cmd = 2'h0;
    logic nmi_request = 1'h0;
    wire stack_clear, service_nmi;
    wire [7:0] reg_rdata;
    wire [11:0] pc_load_value;
    wire instr_retired, return_from_interrupt_instr_executed, stop_request, core_reset, nmi_mode, service_irq;
    wire core_wait, core_stop, ext_reset_n_oe;
    int error_cnt = 0, cmp_count = 0;
    initial forever #5 core_clk = ~core_clk;
    // enable follows pending so a pending request could also wake the core
    core_model partner (.core_clk(core_clk), .core_reset(core_reset), .core_wait(core_wait),
        .core_stop(core_stop), .cmd(cmd), .instr_retired(instr_retired),
        .return_from_interrupt_instr_executed(return_from_interrupt_instr_executed), .stop_request(stop_request));
    watchdog_reset_init #(.STAB_LEN(15)) uut (.core_clk(core_clk), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .opt_hw_activation(opt_hw_activation), .opt_ext_stop_ctrl(1'h0),
        .nmi_pin(1'h1), .ext_reset_n_in(1'h1), .ext_reset_n_out(), .ext_reset_n_oe(ext_reset_n_oe),
        .instr_retired(instr_retired), .stop_request(stop_request), .wait_request(1'h0),
        .return_from_interrupt_instr_executed(return_from_interrupt_instr_executed), .irq_pending(irq_pending), .nmi_request(nmi_request),
        .global_interrupt_enable(irq_pending), .core_reset(core_reset),
        .stack_clear(stack_clear), .pc_load_value(pc_load_value), .nmi_mode(nmi_mode),
        .service_irq(service_irq), .core_wait(core_wait), .core_stop(core_stop),
        .service_nmi(service_nmi));
    // compare and count
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // one-cycle strobes; read data taken in the cycle after the strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'h0;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'h0;
        #1 rd = reg_rdata;
    endtask
    // bounded wait for the reset output to reach a level
    task automatic wait_level(input logic lvl, input int lim);
        for (int i = 0; i < lim && core_reset !== lvl; i++) @(posedge core_clk) #1;
    endtask
    // reset state of vector, mode and register; unmapped read gives zero
    task automatic t_init;
        wait_level(1'h0, 100);
        check(pc_load_value, 12'h0FFE);
        check(nmi_mode, 1'h1);
        rd_reg(8'hD8);
        check(rd, 8'hFE);
        rd_reg(8'h00);
        check(rd, 8'h00);
    endtask
    // return from init with a request waiting goes straight to service
    task automatic t_return_from_interrupt_instr;
        @(posedge core_clk);
        irq_pending <= 1'h1;
        cmd <= 2'h1;
        @(posedge core_clk);
        cmd <= 2'h0;
        for (int i = 0; i < 6 && service_irq !== 1'h1; i++) @(posedge core_clk) #1;
        check(service_irq, 1'h1);
        check(nmi_mode, 1'h0);
        irq_pending <= 1'h0;
    endtask
    // activation sticks, then the counter runs out from 0x40 after one tick
    task automatic t_expire;
        wr(8'hD8, 8'h03);
        wr(8'hD8, 8'h02);
        rd_reg(8'hD8);
        check(rd[0], 1'h1);
        wait_level(1'h1, 3200);
        check(core_reset, 1'h1);
        check(ext_reset_n_oe, 1'h1);
        check(stack_clear, 1'h1);
        wait_level(1'h0, 100);
        rd_reg(8'hD8);
        check(rd, 8'hFE);
    endtask
    // clearing the trigger bit resets within a few edges
    task automatic t_soft;
        wr(8'hD8, 8'hFC);
        wait_level(1'h1, 4);
        check(core_reset, 1'h1);
        wait_level(1'h0, 100);
    endtask
    // forced activation: bit ignores writes, stop falls back to wait
    task automatic t_hw;
        @(posedge core_clk);
        opt_hw_activation <= 1'h1;
        sys_rst <= 1'h1;
        @(posedge core_clk);
        sys_rst <= 1'h0;
        wait_level(1'h0, 100);
        wr(8'hD8, 8'hFE);
        rd_reg(8'hD8);
        check(rd[0], 1'h1);
        @(posedge core_clk);
        cmd <= 2'h2;
        @(posedge core_clk);
        cmd <= 2'h0;
        repeat (4) @(posedge core_clk);
        check({core_stop, core_wait}, 2'h1);
        // nmi with interrupts globally off: serviced, yet the core stays asleep
        nmi_request <= 1'h1;
        @(posedge core_clk);
        @(posedge core_clk);
        nmi_request <= 1'h0;
        #1 check(service_nmi, 1'h1);
        check(core_wait, 1'h1);
    endtask
    task end_of_test;
        $display("errors %0d, compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // main sequence after ten cycles of reset
    initial begin
        repeat (10) @(posedge core_clk);
        sys_rst <= 1'h0;
        t_init;
        t_return_from_interrupt_instr;
        t_expire;
        t_soft;
        t_hw;
        end_of_test;
    end
    // a hang counts as a mismatch; the tests need well under 5000 cycles
    initial begin
        #100_000;
        error_cnt++;
        end_of_test;
    end
endmodule // test_digital_watchdog_reset_init
